// ===== fsip_top.sv
// four-stage pipeline control: fetch, dispatch, execute, complete
// assumes instruction and data memories answer in the cycle they are asked
`timescale 1ns/10ps
`default_nettype none
module fsip_top (
	input wire logic clk,
	input wire logic rst_b,
	output logic imem_req,
	output logic [31:0] imem_addr,
	input wire logic imem_valid,
	input wire fsip_pkg::fsip_instr_t imem_instr,
	output logic dmem_req,
	output logic [31:0] dmem_addr,
	input wire logic [31:0] dmem_rdata,
	output logic ret_valid,
	output logic exc_taken
);
	import fsip_pkg::*;

	logic [31:0] pc_q, pc_d;
	fsip_instr_t dec_q, dec_d;
	logic dvld_q, dvld_d;
	fsip_uop_t iu_q, iu_d, fm_q, fm_d, fa_q, fa_d, fr_q, fr_d, ls_q, ls_d, lse_q, lse_d, nu;
	logic ls_halt_q, ls_halt_d;
	fsip_rob_t rob_q [ROB_DEPTH];
	fsip_rob_t rob_d [ROB_DEPTH];
	fsip_rob_t head_e;
	logic [ROB_AW-1:0] head_q, head_d, tail_q, tail_d;
	logic [ROB_AW:0] cnt_q, cnt_d;
	logic [31:0] irf_q [NREG];
	logic [31:0] irf_d [NREG];
	logic [31:0] frf_q [NREG];
	logic [31:0] frf_d [NREG];
	logic [NREG-1:0] ibusy_q, ibusy_d, fbusy_q, fbusy_d;
	logic is_fp, busy, disp, flush, fe_go;
	logic [31:0] op_a, op_b, ea;

	// ********************************
	// completion view and dispatch decision
	// ********************************
	assign head_e = rob_q[head_q];
	assign flush = head_e.vld & head_e.done & head_e.exc;
	assign ret_valid = head_e.vld & head_e.done & ~head_e.exc;
	assign exc_taken = flush;
	assign is_fp = dec_q.unit == U_FP;
	// scoreboard blocks sources and destination still owned by a rename entry
	assign busy = is_fp ? (fbusy_q[dec_q.ra] | fbusy_q[dec_q.rb] | fbusy_q[dec_q.rd])
		: (ibusy_q[dec_q.ra] | ibusy_q[dec_q.rb] | ibusy_q[dec_q.rd]);
	assign disp = dvld_q & ~flush & (cnt_q != (ROB_AW+1)'(ROB_DEPTH)) & ~busy
		& ~(dec_q.unit == U_LS & ls_halt_q);
	// operands come from the file that belongs to the unit
	assign op_a = is_fp ? frf_q[dec_q.ra] : irf_q[dec_q.ra];
	assign op_b = is_fp ? frf_q[dec_q.rb] : irf_q[dec_q.rb];

	// ********************************
	// stage 1 fetch, stage 2 decode latch
	// ********************************
	assign imem_req = ~flush & (~dvld_q | disp);
	assign imem_addr = pc_q;
	assign fe_go = imem_req & imem_valid;

	// only unconditional relative branches exist, so folding never mispredicts
	always_comb begin
		pc_d = pc_q;
		dec_d = dec_q;
		dvld_d = dvld_q & ~disp;
		if (flush) begin
			pc_d = EXC_VEC;
			dvld_d = 1'b0;
		end else if (fe_go) begin
			if (imem_instr.unit == U_BR) begin
				pc_d = pc_q + {{15{imem_instr.imm[14]}}, imem_instr.imm, 2'b00};
			end else begin
				dec_d = imem_instr;
				dvld_d = 1'b1;
				pc_d = pc_q + PC_STEP;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pc_q <= RESET_PC;
			dec_q <= '0;
			dvld_q <= 1'b0;
		end else begin
			pc_q <= pc_d;
			dec_q <= dec_d;
			dvld_q <= dvld_d;
		end
	end

	// ********************************
	// stage 3 execution units
	// ********************************
	assign ea = ls_q.a + {{17{ls_q.imm[14]}}, ls_q.imm};
	assign dmem_addr = lse_q.a;
	assign dmem_req = lse_q.vld & ~lse_q.exc;

	// every unit latches its uop at the end of dispatch; flush empties them all
	always_comb begin
		nu = '{vld: 1'b1, exc: 1'b0, tag: tail_q, rd: dec_q.rd, a: op_a, b: op_b, imm: dec_q.imm};
		iu_d = '0;
		fm_d = '0;
		ls_d = ls_q;
		if (disp && dec_q.unit == U_INT) iu_d = nu;
		if (disp && is_fp) fm_d = nu;
		if (!ls_halt_q) ls_d = (disp && dec_q.unit == U_LS) ? nu : '0;
		// three float stages, one uop each, so at most three in flight
		fa_d = fm_q;
		fa_d.a = 32'(fm_q.a * fm_q.b);
		fr_d = fa_q;
		fr_d.a = fa_q.a + {{17{fa_q.imm[14]}}, fa_q.imm};
		lse_d = '0;
		if (!ls_halt_q) begin
			lse_d = ls_q;
			lse_d.a = ea;
			lse_d.exc = ea[1:0] != ALIGN_OK;
		end
		// halt at the edge the fault enters stage 2, so no younger load reaches memory
		ls_halt_d = ls_halt_q | (lse_d.vld & lse_d.exc);
		if (flush) begin
			iu_d = '0;
			fm_d = '0;
			fa_d = '0;
			fr_d = '0;
			ls_d = '0;
			lse_d = '0;
			ls_halt_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			iu_q <= '0;
			fm_q <= '0;
			fa_q <= '0;
			fr_q <= '0;
			ls_q <= '0;
			lse_q <= '0;
			ls_halt_q <= 1'b0;
		end else begin
			iu_q <= iu_d;
			fm_q <= fm_d;
			fa_q <= fa_d;
			fr_q <= fr_d;
			ls_q <= ls_d;
			lse_q <= lse_d;
			ls_halt_q <= ls_halt_d;
		end
	end

	// ********************************
	// stage 4 rename entries and completion
	// ********************************
	// finishing units, allocation, retirement, then flush overriding all
	always_comb begin
		rob_d = rob_q;
		irf_d = irf_q;
		frf_d = frf_q;
		ibusy_d = ibusy_q;
		fbusy_d = fbusy_q;
		head_d = head_q;
		tail_d = tail_q;
		cnt_d = cnt_q;
		if (iu_q.vld) begin
			rob_d[iu_q.tag].done = 1'b1;
			rob_d[iu_q.tag].val = iu_q.a + iu_q.b;
		end
		if (fr_q.vld) begin
			rob_d[fr_q.tag].done = 1'b1;
			rob_d[fr_q.tag].val = fr_q.a;
		end
		if (lse_q.vld) begin
			rob_d[lse_q.tag].done = 1'b1;
			rob_d[lse_q.tag].exc = lse_q.exc;
			rob_d[lse_q.tag].val = lse_q.exc ? 32'h0000_0000 : dmem_rdata;
		end
		if (disp) begin
			rob_d[tail_q] = '{vld: 1'b1, done: 1'b0, exc: 1'b0, isfp: is_fp, rd: dec_q.rd, val: '0};
			if (is_fp) fbusy_d[dec_q.rd] = 1'b1;
			else ibusy_d[dec_q.rd] = 1'b1;
			tail_d = tail_q + 1'b1;
		end
		if (ret_valid) begin
			rob_d[head_q].vld = 1'b0;
			if (head_e.isfp) begin
				frf_d[head_e.rd] = head_e.val;
				fbusy_d[head_e.rd] = 1'b0;
			end else begin
				irf_d[head_e.rd] = head_e.val;
				ibusy_d[head_e.rd] = 1'b0;
			end
			head_d = head_q + 1'b1;
		end
		cnt_d = cnt_q + (ROB_AW+1)'(disp) - (ROB_AW+1)'(ret_valid);
		if (flush) begin
			for (int i = 0; i < ROB_DEPTH; i++) rob_d[i].vld = 1'b0;
			ibusy_d = '0;
			fbusy_d = '0;
			head_d = '0;
			tail_d = '0;
			cnt_d = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int i = 0; i < ROB_DEPTH; i++) rob_q[i] <= '0;
			for (int i = 0; i < NREG; i++) begin
				irf_q[i] <= '0;
				frf_q[i] <= '0;
			end
			ibusy_q <= '0;
			fbusy_q <= '0;
			head_q <= '0;
			tail_q <= '0;
			cnt_q <= '0;
		end else begin
			rob_q <= rob_d;
			irf_q <= irf_d;
			frf_q <= frf_d;
			ibusy_q <= ibusy_d;
			fbusy_q <= fbusy_d;
			head_q <= head_d;
			tail_q <= tail_d;
			cnt_q <= cnt_d;
		end
	end

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	no_branch_disp_a: assert property (disp |-> dec_q.unit != U_BR)
		else $error("branch reached dispatch");
	disp_room_a: assert property (disp |-> cnt_q < 3'(ROB_DEPTH) && !busy)
		else $error("dispatch without room or with busy operand");
	iu_oper_a: assert property (disp && dec_q.unit == U_INT |=> iu_q.vld && iu_q.a == $past(op_a))
		else $error("integer operand not latched");
	fp_latch_a: assert property (disp && is_fp && !flush |=> fm_q.vld && fm_q.tag == $past(tail_q))
		else $error("float unit did not latch dispatch");
	fp_order_a: assert property (fm_q.vld && !flush |=> fa_q.vld ##1 (fr_q.vld || $past(flush)))
		else $error("float stage order broken");
	ls_stage_a: assert property (ls_q.vld && !ls_halt_q && !flush |=> lse_q.vld && lse_q.tag == $past(ls_q.tag))
		else $error("load/store second stage missed");
	ls_halt_a: assert property (ls_halt_q && !flush |=> !lse_q.vld)
		else $error("load/store ran while halted");
	ls_stop_a: assert property (lse_q.vld && lse_q.exc && !flush |=> !lse_q.vld)
		else $error("load after a fault reached stage 2");
	exc_head_a: assert property (exc_taken |-> head_e.vld && head_e.done && head_e.exc && !ret_valid && !disp && !imem_req)
		else $error("exception raised before head");
	flush_a: assert property (exc_taken |=> cnt_q == '0 && pc_q == EXC_VEC && !dvld_q && !fm_q.vld)
		else $error("flush incomplete");
	ret_order_a: assert property (ret_valid && !disp |=> head_q == $past(head_q) + 2'h1 && cnt_q == $past(cnt_q) - 3'h1)
		else $error("retire out of order");

	fold_c: cover property (fe_go && imem_instr.unit == U_BR);
	fp_full_c: cover property (fm_q.vld && fa_q.vld && fr_q.vld);
	exc_c: cover property (exc_taken);
	retire_c: cover property (ret_valid ##1 ret_valid);
endmodule
`default_nettype wire

// ===== fsip_pkg.sv
// types and constants shared by the four-stage pipeline control
// assumes a single processor clock and one instruction word per fetch
package fsip_pkg;

	// ********************************
	// sizes and addresses
	// ********************************
	localparam int ROB_DEPTH = 4;
	localparam int ROB_AW = 2;
	localparam int NREG = 32;
	localparam logic [31:0] RESET_PC = 32'h0000_0000;
	localparam logic [31:0] EXC_VEC = 32'h0000_0700; // arbitrary handler entry
	localparam logic [31:0] PC_STEP = 32'h0000_0004;
	localparam logic [1:0] ALIGN_OK = 2'h0;

	// ********************************
	// instruction and micro-op layouts
	// ********************************
	typedef enum logic [1:0] {U_INT, U_FP, U_LS, U_BR} fsip_unit_t;

	typedef struct packed {
		fsip_unit_t unit;
		logic [4:0] rd;
		logic [4:0] ra;
		logic [4:0] rb;
		logic [14:0] imm;
	} fsip_instr_t;

	typedef struct packed {
		logic vld;
		logic exc;
		logic [ROB_AW-1:0] tag;
		logic [4:0] rd;
		logic [31:0] a;
		logic [31:0] b;
		logic [14:0] imm;
	} fsip_uop_t;

	typedef struct packed {
		logic vld;
		logic done;
		logic exc;
		logic isfp;
		logic [4:0] rd;
		logic [31:0] val;
	} fsip_rob_t;

endpackage

// ===== fsip_mem_model.sv
// instruction and data memory model facing the pipeline control
// assumes the bench loads prog before releasing reset
`timescale 1ns/10ps
`default_nettype none
module fsip_mem_model
	import fsip_pkg::*;
(
	input wire logic clk,
	input wire logic slow,
	input wire logic imem_req,
	input wire logic [31:0] imem_addr,
	output logic imem_valid,
	output fsip_pkg::fsip_instr_t imem_instr,
	input wire logic dmem_req,
	input wire logic [31:0] dmem_addr,
	output logic [31:0] dmem_rdata
);
	// ********************************
	// storage and answers
	// ********************************
	fsip_instr_t prog [0:511];
	fsip_instr_t ilast_q;
	logic [31:0] dlast_q;
	logic tog_q = 1'b0;
	// slow mode answers every other cycle to stretch fetch
	assign imem_valid = imem_req && (!slow || tog_q);
	// idle lines show the inverse of the previous cycle's lines, so every second idle cycle repeats the last word
	assign imem_instr = imem_valid ? prog[imem_addr[10:2]] : ~ilast_q;
	assign dmem_rdata = dmem_req ? ~dmem_addr : ~dlast_q;
	// remember what was last put on the lines
	always @(posedge clk) begin
		tog_q <= ~tog_q;
		ilast_q <= imem_instr;
		dlast_q <= dmem_rdata;
	end
endmodule
`default_nettype wire

// ===== test_four_stage_instruction_pipeline.sv
// self-checking bench for the four-stage pipeline control
// assumes the memory model answers fetches in the same cycle
`timescale 1ns/10ps
`default_nettype none
module test_four_stage_instruction_pipeline;
	import fsip_pkg::*;
	// ********************************
	// signals and instances
	// ********************************
	typedef struct packed {
		fsip_instr_t ins;
		logic [3:0] nret;
		logic nexc;
		logic [31:0] pc;
		logic [31:0] ea;
	} fsip_row_t;
	localparam fsip_instr_t SELF = '{U_BR, 5'h00, 5'h00, 5'h00, 15'h0000};
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic slow = 1'b0;
	logic imem_req, imem_valid, dmem_req, ret_valid, exc_taken;
	logic [31:0] imem_addr, dmem_addr, dmem_rdata;
	fsip_instr_t imem_instr;
	int failures = 0;
	int samples_checked = 0;
	fsip_row_t rows [6];
	fsip_top u_fsip_top (.clk(clk), .rst_b(rst_b), .imem_req(imem_req),
		.imem_addr(imem_addr), .imem_valid(imem_valid), .imem_instr(imem_instr),
		.dmem_req(dmem_req), .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata),
		.ret_valid(ret_valid), .exc_taken(exc_taken));
	fsip_mem_model u_fsip_mem_model (.clk(clk), .slow(slow), .imem_req(imem_req),
		.imem_addr(imem_addr), .imem_valid(imem_valid), .imem_instr(imem_instr),
		.dmem_req(dmem_req), .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata));
	// free-running 10 MHz clock
	initial begin
		forever #50 clk = ~clk;
	end
	// ********************************
	// helpers
	// ********************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (failures == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// loads four words at 0, restarts, counts retires and exceptions over a fixed window
	task automatic run(input fsip_instr_t p0, p1, p2, p3, input logic s,
		input int eret, input int eexc, input logic [31:0] epc, input logic [31:0] eea);
		int nret;
		int nexc;
		logic [31:0] ea;
		for (int i = 0; i < 512; i++) begin
			u_fsip_mem_model.prog[i] = SELF;
		end
		u_fsip_mem_model.prog[0] = p0;
		u_fsip_mem_model.prog[1] = p1;
		u_fsip_mem_model.prog[2] = p2;
		u_fsip_mem_model.prog[3] = p3;
		slow = s;
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		check(imem_addr, RESET_PC);
		rst_b = 1'b1;
		nret = 0;
		nexc = 0;
		ea = 32'h0000_0000;
		repeat (40) @(negedge clk) begin
			if (ret_valid === 1'b1) nret++;
			if (exc_taken === 1'b1) nexc++;
			if (dmem_req === 1'b1) ea = dmem_addr;
		end
		check(32'(nret), 32'(eret));
		check(32'(nexc), 32'(eexc));
		check(imem_addr, epc);
		check(ea, eea);
	endtask
	// ********************************
	// main sequence
	// ********************************
	initial begin
		rows[0] = '{'{U_INT, 5'h01, 5'h00, 5'h00, 15'h0000}, 4'h1, 1'b0, 32'h4, 32'h0};
		rows[1] = '{'{U_FP, 5'h01, 5'h00, 5'h00, 15'h0005}, 4'h1, 1'b0, 32'h4, 32'h0};
		rows[2] = '{'{U_LS, 5'h01, 5'h00, 5'h00, 15'h0008}, 4'h1, 1'b0, 32'h4, 32'h8};
		rows[3] = '{'{U_LS, 5'h01, 5'h00, 5'h00, 15'h0002}, 4'h0, 1'b1, EXC_VEC, 32'h0};
		rows[4] = '{'{U_BR, 5'h00, 5'h00, 5'h00, 15'h0003}, 4'h0, 1'b0, 32'hC, 32'h0};
		rows[5] = '{'{U_BR, 5'h00, 5'h00, 5'h00, 15'h7FFF}, 4'h0, 1'b0, 32'hFFFF_FFFC, 32'h0};
		repeat (15) @(negedge clk);
		check(32'({imem_req, dmem_req, ret_valid, exc_taken}), 32'h8);
		check(imem_addr, RESET_PC);
		@(negedge clk);
		// single instructions of every unit kind, then self-branch filler
		foreach (rows[i]) begin
			run(rows[i].ins, SELF, SELF, SELF, 1'b0, rows[i].nret, rows[i].nexc,
				rows[i].pc, rows[i].ea);
		end
		// faulting load at head cancels the one younger instruction fetched before the flush, slow fetch side
		run('{U_LS, 5'h01, 5'h00, 5'h00, 15'h0002}, '{U_INT, 5'h02, 5'h00, 5'h00, 15'h0},
			'{U_FP, 5'h03, 5'h00, 5'h00, 15'h0}, '{U_INT, 5'h04, 5'h00, 5'h00, 15'h0},
			1'b1, 0, 1, EXC_VEC, 32'h0);
		// mixed units finishing out of order, the last reading integer r1, not the float result
		run('{U_FP, 5'h01, 5'h00, 5'h00, 15'h1}, '{U_INT, 5'h02, 5'h00, 5'h00, 15'h0},
			'{U_LS, 5'h03, 5'h00, 5'h00, 15'h4}, '{U_INT, 5'h04, 5'h01, 5'h00, 15'h0},
			1'b0, 4, 0, 32'h10, 32'h4);
		// three floats back to back fill all three float stages at once
		run('{U_FP, 5'h01, 5'h00, 5'h00, 15'h1}, '{U_FP, 5'h02, 5'h00, 5'h00, 15'h2},
			'{U_FP, 5'h03, 5'h00, 5'h00, 15'h3}, '{U_INT, 5'h04, 5'h00, 5'h00, 15'h0},
			1'b0, 4, 0, 32'h10, 32'h0);
		// good load retires, the misaligned one faults, the load behind it never reaches memory
		run('{U_LS, 5'h01, 5'h00, 5'h00, 15'h8}, '{U_LS, 5'h02, 5'h00, 5'h00, 15'h6},
			'{U_LS, 5'h03, 5'h00, 5'h00, 15'h10}, SELF, 1'b0, 1, 1, EXC_VEC, 32'h8);
		// retired load word (model returns ~address, so ~8) is the next load's base
		run('{U_LS, 5'h01, 5'h00, 5'h00, 15'h8}, '{U_LS, 5'h02, 5'h01, 5'h00, 15'h15},
			SELF, SELF, 1'b0, 2, 0, 32'h8, 32'hC);
		tally_and_finish();
	end
endmodule
`default_nettype wire
